// ---- inc/sample_map_pkg.sv ----
// sample mapper package: frame layouts, lane counts and mode codes
// assumes one frame of samples per frame clock, lane words sent msb first
package sample_map_pkg;

  // converter and lane geometry
  localparam int NUM_CH = 4;              // channels a, b, c, d
  localparam int SAMP_PER_CH = 10;        // most samples of one channel per frame
  localparam int SAMP_W = 12;             // converter resolution
  localparam int NUM_LANES = 8;           // serial lane drivers
  localparam int LANE_W = 64;             // widest lane frame, eight octets
  localparam int MODE_W = 4;              // width of the link mode setting
  localparam int TAIL_W = 4;              // tail bits of the 12-bit eight-lane mode

  // link mode codes
  localparam logic [3:0] MODE_12B_8L = 4'h0;
  localparam logic [3:0] MODE_12B_6L = 4'h1;
  localparam logic [3:0] MODE_8B_4L = 4'h2;
  localparam logic [3:0] MODE_10B_4L = 4'h3;
  localparam logic [3:0] MODE_12B_3L_66 = 4'h4;
  localparam logic [3:0] MODE_8B_2L_66 = 4'h5;
  localparam logic [3:0] MODE_12B_6L_66 = 4'h6;
  localparam logic [3:0] MODE_8B_4L_66 = 4'h7;
  localparam logic [3:0] MODE_LAST = 4'h7; // highest mode this mapper packs

  // active lane masks, lowest lanes first
  localparam logic [7:0] LANES_8 = 8'hFF;
  localparam logic [7:0] LANES_6 = 8'h3F;
  localparam logic [7:0] LANES_4 = 8'h0F;
  localparam logic [7:0] LANES_3 = 8'h07;
  localparam logic [7:0] LANES_2 = 8'h03;
  localparam logic [7:0] LANES_0 = 8'h00;

  // reset values
  localparam logic RST_VALID = 1'b0;
  localparam logic RST_READY = 1'b0;

  // one frame of samples: ch index 0..3 is a..d, n index is sample time
  typedef logic [SAMP_W-1:0] sample_t;
  typedef struct packed {
    logic [MODE_W-1:0] link_mode_select;
    sample_t [NUM_CH-1:0][SAMP_PER_CH-1:0] ch;
  } samp_frame_t;

  // one packed frame on all lanes, first bit sent is bit LANE_W-1
  typedef struct packed {
    logic [MODE_W-1:0] link_mode_select;
    logic [NUM_LANES-1:0] lane_enable;
    logic [NUM_LANES-1:0][LANE_W-1:0] serial_lane;
  } lane_frame_t;

endpackage : sample_map_pkg

// ---- design/sample_mapper.sv ----
// transport sample mapper: packs one frame of channel samples into lane words
// assumes samples arrive msb-aligned at 12 bits; link layer serialises msb first
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Operation
// - mode selects one fixed lane arrangement; modes 6 and 7 reuse those of modes 1 and 2
// - arrangement repeats every frame, times advance
// - leftover tail bits always driven zero
// - samples placed msb first, lsb last
// - labels are channel plus in-frame time index
// - mode 0: five samples, four-bit tail
// - mode 1: split pairs over six lanes
// - mode 2: one octet per channel lane
// - mode 3: four 10-bit samples per lane
// - mode 4: A0 B0 C0 D0 over three lanes
// - mode 5: two octets on two lanes
// - mode 6: same split as mode 1
// - mode 7: one octet per channel lane
// - lowest lanes used, upper lanes powered down
module sample_mapper
  import sample_map_pkg::*;
#(
  parameter int LANES = NUM_LANES  // lane drivers present
)
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire samp_frame_t in_frame,
  input wire logic in_valid,
  output logic in_ready,
  output lane_frame_t out_frame,
  output logic out_valid,
  input wire logic out_ready
);

  //////////////////////////////////////////////////////////////////////////////
  // sample views at each resolution
  wire [MODE_W-1:0] mode = in_frame.link_mode_select;  // mode of this frame
  wire [NUM_CH-1:0][7:0] s8;                     // sample 0 cut to 8 bits
  wire [NUM_CH-1:0][39:0] s10x4;                 // samples 0..3 cut to 10 bits
  wire [1:0][47:0] pair_split;                   // two-channel, two-sample streams
  wire [47:0] quad_split;                        // sample 0 of all four channels
  wire [NUM_LANES-1:0][LANE_W-1:0] mapped;       // lane words for this mode
  logic [NUM_LANES-1:0] lane_mask;               // lanes in use for this mode

  // per-channel views; upper bits kept so the msb leads
  genvar c;
  generate
    for (c = 0; c < NUM_CH; c++)
    begin : g_ch
      assign s8[c] = in_frame.ch[c][0][11:4];
      assign s10x4[c] = {in_frame.ch[c][0][11:2], in_frame.ch[c][1][11:2],
                         in_frame.ch[c][2][11:2], in_frame.ch[c][3][11:2]};
    end
  endgenerate

  // bit streams cut into 16-bit lanes for the split modes
  assign pair_split[0] = {in_frame.ch[0][0], in_frame.ch[0][1],
                          in_frame.ch[1][0], in_frame.ch[1][1]};
  assign pair_split[1] = {in_frame.ch[2][0], in_frame.ch[2][1],
                          in_frame.ch[3][0], in_frame.ch[3][1]};
  assign quad_split = {in_frame.ch[0][0], in_frame.ch[1][0],
                       in_frame.ch[2][0], in_frame.ch[3][0]};

  //////////////////////////////////////////////////////////////////////////////
  // lane use per mode, lowest lanes first
  always_comb
  begin
    case (mode)
      MODE_12B_8L: lane_mask = LANES_8;
      MODE_12B_6L, MODE_12B_6L_66: lane_mask = LANES_6;
      MODE_8B_4L, MODE_10B_4L, MODE_8B_4L_66: lane_mask = LANES_4;
      MODE_12B_3L_66: lane_mask = LANES_3;
      MODE_8B_2L_66: lane_mask = LANES_2;
      default: lane_mask = LANES_0;  // unsupported mode: all lanes down
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // per-lane word for each mode, left-aligned, unused low bits zero
  genvar l;
  generate
    for (l = 0; l < NUM_LANES; l++)
    begin : g_lane
      localparam int CH0 = l / 2;      // channel of an eight-lane lane
      localparam int PAR = l % 2;      // even or odd sample times
      localparam int GRP = (l / 3) % 2; // channel pair of a split lane
      localparam int SEG = l % 3;      // 16-bit slice of a split stream
      wire [LANE_W-1:0] w_m0;          // five samples plus tail
      wire [LANE_W-1:0] w_m16;         // split mode slice
      wire [LANE_W-1:0] w_m4;          // four-channel split slice
      wire [LANE_W-1:0] w_m8;          // one octet
      wire [LANE_W-1:0] w_m10;         // four 10-bit samples
      wire [LANE_W-1:0] w_m5;          // two octets
      wire [LANE_W-1:0] w_sel;         // word of the selected mode

      assign w_m0 = {in_frame.ch[CH0][PAR], in_frame.ch[CH0][PAR+2],
                     in_frame.ch[CH0][PAR+4], in_frame.ch[CH0][PAR+6],
                     in_frame.ch[CH0][PAR+8], {TAIL_W{1'b0}}};
      assign w_m16 = {pair_split[GRP][47-16*SEG -: 16], 48'h0000_0000_0000};
      assign w_m4 = {quad_split[47-16*SEG -: 16], 48'h0000_0000_0000};
      assign w_m8 = {s8[l % NUM_CH], 56'h00_0000_0000_0000};
      assign w_m10 = {s10x4[l % NUM_CH], 24'h00_0000};
      assign w_m5 = {s8[2*(l % 2)], s8[2*(l % 2)+1], 48'h0000_0000_0000};

      // mode decode, one arrangement each
      assign w_sel = (mode == MODE_12B_8L) ? w_m0 :
                     (mode == MODE_12B_6L || mode == MODE_12B_6L_66) ? w_m16 :
                     (mode == MODE_8B_4L || mode == MODE_8B_4L_66) ? w_m8 :
                     (mode == MODE_10B_4L) ? w_m10 :
                     (mode == MODE_12B_3L_66) ? w_m4 :
                     (mode == MODE_8B_2L_66) ? w_m5 : '0;
      assign mapped[l] = (lane_mask[l] && l < LANES) ? w_sel : '0;
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // two-entry buffer: output stage plus skid stage
  lane_frame_t head_r;      // frame on the outputs
  lane_frame_t skid_r;      // frame caught while stalled
  logic head_valid_r;       // output stage full
  logic skid_valid_r;       // skid stage full
  logic in_ready_r;         // room for one more frame
  lane_frame_t packed_in;   // freshly mapped frame
  wire take = in_valid && in_ready_r;              // frame accepted
  wire drain = !head_valid_r || out_ready;         // output stage free
  wire skid_valid_nxt = drain ? 1'b0 : (skid_valid_r || take);
  wire head_valid_nxt = drain ? (skid_valid_r || take) : 1'b1;

  assign packed_in.link_mode_select = mode;
  assign packed_in.lane_enable = lane_mask;
  assign packed_in.serial_lane = mapped;

  // buffer control flags
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      head_valid_r <= RST_VALID;
      skid_valid_r <= RST_VALID;
      in_ready_r <= RST_READY;
    end
    else
    begin
      head_valid_r <= head_valid_nxt;
      skid_valid_r <= skid_valid_nxt;
      in_ready_r <= !skid_valid_nxt;  // stall reaches the source
    end
  end

  // buffer data: skid drains first so frame order holds
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      head_r <= '0;
      skid_r <= '0;
    end
    else
    begin
      if (drain && skid_valid_r)
        head_r <= skid_r;
      else if (drain && take)
        head_r <= packed_in;
      if (!drain && take)
        skid_r <= packed_in;
    end
  end

  assign out_frame = head_r;
  assign out_valid = head_valid_r;
  assign in_ready = in_ready_r;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  wire direct = take && drain && !skid_valid_r;  // frame goes straight out

  property p_direct_out;
    @(posedge mclk) disable iff (!reset_n)
    direct |=> out_valid && out_frame == $past(packed_in);
  endproperty
  a_direct_out: assert property (p_direct_out)
    else $error("accepted frame not on outputs next cycle");

  property p_mode0_lane1;
    @(posedge mclk) disable iff (!reset_n)
    direct && mode == MODE_12B_8L |=>
      out_frame.serial_lane[1] == {$past(in_frame.ch[0][1]), $past(in_frame.ch[0][3]),
        $past(in_frame.ch[0][5]), $past(in_frame.ch[0][7]), $past(in_frame.ch[0][9]), 4'h0};
  endproperty
  a_mode0_lane1: assert property (p_mode0_lane1)
    else $error("mode 0 lane 1 not odd channel a samples");

  property p_tail_zero;
    @(posedge mclk) disable iff (!reset_n)
    out_valid && out_frame.link_mode_select == MODE_12B_8L |->
      out_frame.serial_lane[7][3:0] == 4'h0 && out_frame.serial_lane[4][3:0] == 4'h0;
  endproperty
  a_tail_zero: assert property (p_tail_zero)
    else $error("tail bits not zero");

  property p_mode1_lane1;
    @(posedge mclk) disable iff (!reset_n)
    direct && mode == MODE_12B_6L |=>
      out_frame.serial_lane[1][63:48] ==
        {$past(in_frame.ch[0][1][7:0]), $past(in_frame.ch[1][0][11:4])};
  endproperty
  a_mode1_lane1: assert property (p_mode1_lane1)
    else $error("mode 1 lane 1 split wrong");

  property p_mode6_lane4;
    @(posedge mclk) disable iff (!reset_n)
    direct && mode == MODE_12B_6L_66 |=>
      out_frame.serial_lane[4][63:48] ==
        {$past(in_frame.ch[2][1][7:0]), $past(in_frame.ch[3][0][11:4])};
  endproperty
  a_mode6_lane4: assert property (p_mode6_lane4)
    else $error("mode 6 lane 4 split wrong");

  property p_mode2_lane3;
    @(posedge mclk) disable iff (!reset_n)
    direct && mode == MODE_8B_4L |=>
      out_frame.serial_lane[3][63:56] == $past(in_frame.ch[3][0][11:4]);
  endproperty
  a_mode2_lane3: assert property (p_mode2_lane3)
    else $error("mode 2 lane 3 not channel d");

  property p_mode3_lane2;
    @(posedge mclk) disable iff (!reset_n)
    direct && mode == MODE_10B_4L |=>
      out_frame.serial_lane[2][33:24] == $past(in_frame.ch[2][3][11:2]);
  endproperty
  a_mode3_lane2: assert property (p_mode3_lane2)
    else $error("mode 3 lane 2 last sample wrong");

  property p_mode4_lane2;
    @(posedge mclk) disable iff (!reset_n)
    direct && mode == MODE_12B_3L_66 |=>
      out_frame.serial_lane[2][63:48] ==
        {$past(in_frame.ch[2][0][3:0]), $past(in_frame.ch[3][0])};
  endproperty
  a_mode4_lane2: assert property (p_mode4_lane2)
    else $error("mode 4 lane 2 wrong");

  property p_mode5_lane1;
    @(posedge mclk) disable iff (!reset_n)
    direct && mode == MODE_8B_2L_66 |=>
      out_frame.serial_lane[1][63:48] ==
        {$past(in_frame.ch[2][0][11:4]), $past(in_frame.ch[3][0][11:4])};
  endproperty
  a_mode5_lane1: assert property (p_mode5_lane1)
    else $error("mode 5 lane 1 wrong");

  property p_mode7_lane0;
    @(posedge mclk) disable iff (!reset_n)
    direct && mode == MODE_8B_4L_66 |=>
      out_frame.serial_lane[0] == {$past(in_frame.ch[0][0][11:4]), 56'h00_0000_0000_0000};
  endproperty
  a_mode7_lane0: assert property (p_mode7_lane0)
    else $error("mode 7 lane 0 wrong");

  property p_lanes_down;
    @(posedge mclk) disable iff (!reset_n)
    out_valid && !out_frame.lane_enable[5] |-> out_frame.serial_lane[5] == '0;
  endproperty
  a_lanes_down: assert property (p_lanes_down)
    else $error("powered down lane carries data");

  property p_hold_stall;
    @(posedge mclk) disable iff (!reset_n)
    out_valid && !out_ready |=> out_valid && $stable(out_frame);
  endproperty
  a_hold_stall: assert property (p_hold_stall)
    else $error("frame changed while stalled");

endmodule : sample_mapper

// ---- verification/lane_sink_model.sv ----
// link-layer side model: takes packed lane frames from the mapper and keeps them
// assumes the frame clock is shared and stall is driven by the bench
`timescale 1ns/1ps

module lane_sink_model
  import sample_map_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire lane_frame_t out_frame,
  input wire logic out_valid,
  output logic out_ready,
  input wire logic stall
);
  lane_frame_t got[$]; // frames taken, in arrival order
  sample_t chan_a[$]; // channel a rebuilt in time order from mode 0 lanes

  ////////////////////////////////////////////////////////////////////////////
  // ready follows the stall request just after each edge
  always @(posedge mclk)
  begin
    out_ready <= #1 ~stall;
  end

  // capture a frame at every edge with valid and ready both high
  always @(posedge mclk)
  begin
    if (reset_n && out_valid === 1'b1 && out_ready)
    begin
      got.push_back(out_frame);
      // mode 0 splits channel a over lanes 0 and 1: interleave back to time order
      if (out_frame.link_mode_select == MODE_12B_8L)
      begin
        for (int t = 0; t < 5; t++)
        begin
          chan_a.push_back(out_frame.serial_lane[0][63-12*t -: 12]);
          chan_a.push_back(out_frame.serial_lane[1][63-12*t -: 12]);
        end
      end
    end
  end
endmodule : lane_sink_model

// ---- verification/jesd_transport_sample_mapper_tb_top.sv ----
// testbench: drives sample frames into the mapper and checks lane words
// assumes a 100 MHz frame clock and the lane_sink_model on the output side
`timescale 1ns/1ps

module jesd_transport_sample_mapper_tb_top
  import sample_map_pkg::*;
;
  localparam int FW = $bits(lane_frame_t); // widest compared value
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic in_valid = 1'b0;
  logic stall = 1'b0; // asks the sink to hold ready low
  samp_frame_t in_frame = '0;
  logic in_ready;
  logic out_valid;
  logic out_ready;
  lane_frame_t out_frame;
  lane_frame_t exp_q[$]; // frames expected, in take order
  int mismatches = 0;
  int compares = 0;

  sample_mapper u_dut (.mclk(mclk), .reset_n(reset_n), .in_frame(in_frame),
    .in_valid(in_valid), .in_ready(in_ready), .out_frame(out_frame),
    .out_valid(out_valid), .out_ready(out_ready));
  lane_sink_model u_sink (.mclk(mclk), .reset_n(reset_n), .out_frame(out_frame),
    .out_valid(out_valid), .out_ready(out_ready), .stall(stall));

  ////////////////////////////////////////////////////////////////////////////
  // clock and watchdog
  initial forever #5 mclk = ~mclk;
  initial
  begin
    #20000;
    mismatches++;
    report_and_stop();
  end

  ////////////////////////////////////////////////////////////////////////////
  // reference mapping, worked out per mode, msb first, tails zero
  function automatic lane_frame_t map_exp(samp_frame_t f);
    lane_frame_t r;
    logic [47:0] w;
    r = '0;
    r.link_mode_select = f.link_mode_select;
    case (f.link_mode_select)
      4'h0:
      begin
        r.lane_enable = 8'hFF;
        for (int l = 0; l < 8; l++)
          r.serial_lane[l] = {f.ch[l/2][l%2], f.ch[l/2][l%2+2], f.ch[l/2][l%2+4],
            f.ch[l/2][l%2+6], f.ch[l/2][l%2+8], 4'h0};
      end
      4'h1, 4'h6:
      begin
        r.lane_enable = 8'h3F;
        for (int h = 0; h < 2; h++)
        begin
          w = {f.ch[2*h][0], f.ch[2*h][1], f.ch[2*h+1][0], f.ch[2*h+1][1]};
          for (int p = 0; p < 3; p++)
            r.serial_lane[3*h+p] = {w[47-16*p -: 16], 48'h0};
        end
      end
      4'h2, 4'h7:
      begin
        r.lane_enable = 8'h0F;
        for (int c = 0; c < 4; c++)
          r.serial_lane[c] = {f.ch[c][0][11:4], 56'h0};
      end
      4'h3:
      begin
        r.lane_enable = 8'h0F;
        for (int c = 0; c < 4; c++)
          r.serial_lane[c] = {f.ch[c][0][11:2], f.ch[c][1][11:2], f.ch[c][2][11:2],
            f.ch[c][3][11:2], 24'h0};
      end
      4'h4:
      begin
        r.lane_enable = 8'h07;
        w = {f.ch[0][0], f.ch[1][0], f.ch[2][0], f.ch[3][0]};
        for (int p = 0; p < 3; p++)
          r.serial_lane[p] = {w[47-16*p -: 16], 48'h0};
      end
      4'h5:
      begin
        r.lane_enable = 8'h03;
        r.serial_lane[0] = {f.ch[0][0][11:4], f.ch[1][0][11:4], 48'h0};
        r.serial_lane[1] = {f.ch[2][0][11:4], f.ch[3][0][11:4], 48'h0};
      end
      default: ; // unsupported codes keep every lane down
    endcase
    return r;
  endfunction : map_exp

  // distinct samples per channel, time and frame number k
  function automatic samp_frame_t mk(logic [3:0] m, logic [3:0] k);
    samp_frame_t r;
    r.link_mode_select = m;
    for (int c = 0; c < 4; c++)
      for (int n = 0; n < 10; n++)
        r.ch[c][n] = {k ^ 4'(c*5+8), 4'(n) + k, 4'hA ^ 4'(c)};
    return r;
  endfunction : mk

  ////////////////////////////////////////////////////////////////////////////
  // shared checking, driving and closing tasks
  task automatic chk(input logic [FW-1:0] got, input logic [FW-1:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  // offer a frame and hold it until an edge with in_ready high takes it
  task automatic send(input samp_frame_t f);
    in_frame = f;
    in_valid = 1'b1;
    for (int i = 0; i < 40; i++)
    begin
      if (in_ready === 1'b1)
      begin
        @(posedge mclk);
        #1;
        exp_q.push_back(map_exp(f));
        return;
      end
      @(posedge mclk);
      #1;
    end
    mismatches++;
  endtask : send

  // stop offering, wait for the sink to hold every frame, compare in order
  task automatic drain();
    in_valid = 1'b0;
    for (int i = 0; i < 40 && u_sink.got.size() < exp_q.size(); i++)
    begin
      @(posedge mclk);
      #1;
    end
    chk(FW'(u_sink.got.size()), FW'(exp_q.size()));
    foreach (exp_q[i])
      if (i < u_sink.got.size())
        chk(u_sink.got[i], exp_q[i]);
    u_sink.got.delete();
    exp_q.delete();
  endtask : drain

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic test_reset();
    repeat (4) @(posedge mclk);
    #1;
    chk(FW'(in_ready), FW'(0)); // RESET
    chk(FW'(out_valid), FW'(0)); // RESET
    chk(out_frame, '0); // RESET
    reset_n = 1'b1;
    @(posedge mclk);
    #1;
    chk(FW'(in_ready), FW'(1)); // RESET
  endtask : test_reset

  // every mode plus an unsupported code, two back-to-back frames each
  task automatic test_modes();
    logic [3:0] modes[9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hF};
    samp_frame_t f0; // mode 0 frame whose channel a is expected
    foreach (modes[i])
      for (int k = 0; k < 2; k++)
      begin
        send(mk(modes[i], 4'(k + i)));
        chk(FW'(out_valid), FW'(1));
        chk(out_frame, map_exp(mk(modes[i], 4'(k + i))));
      end
    drain();
    // two mode 0 frames give channel a samples 0..9 of frame 0, then of frame 1
    chk(FW'(u_sink.chan_a.size()), FW'(20));
    for (int n = 0; n < 20; n++)
    begin
      f0 = mk(4'h0, 4'(n / 10));
      if (n < u_sink.chan_a.size())
        chk(FW'(u_sink.chan_a[n]), FW'(f0.ch[0][n % 10]));
    end
    u_sink.chan_a.delete();
  endtask : test_modes

  // receiver stalls: skid fills, third frame refused, outputs stand, order kept
  task automatic test_stall();
    stall = 1'b1;
    @(posedge mclk);
    #1;
    send(mk(4'h0, 4'h3));
    send(mk(4'h3, 4'h4));
    chk(FW'(in_ready), FW'(0));
    in_frame = mk(4'h5, 4'h6);
    repeat (3) @(posedge mclk);
    #1;
    chk(FW'(in_ready), FW'(0));
    chk(out_frame, map_exp(mk(4'h0, 4'h3)));
    stall = 1'b0;
    send(mk(4'h5, 4'h6));
    drain();
  endtask : test_stall

  // reset in mid-run with both buffer stages full clears them at once
  task automatic test_reset_mid();
    stall = 1'b1;
    send(mk(4'h1, 4'h5));
    send(mk(4'h6, 4'h7));
    in_valid = 1'b0;
    reset_n = 1'b0;
    #1;
    chk(FW'(out_valid), FW'(0)); // RESET
    chk(FW'(in_ready), FW'(0)); // RESET
    chk(out_frame, '0); // RESET
    exp_q.delete();
    stall = 1'b0;
    @(posedge mclk);
    #1;
    reset_n = 1'b1;
    @(posedge mclk);
    #1;
    chk(FW'(in_ready), FW'(1)); // RESET
    u_sink.got.delete();
    send(mk(4'h4, 4'h8));
    drain();
  endtask : test_reset_mid

  initial
  begin
    test_reset();
    test_modes();
    test_stall();
    test_reset_mid();
    report_and_stop();
  end
endmodule : jesd_transport_sample_mapper_tb_top
